//--- core/tbi_pkg.sv
package tbi_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0]  TIME_BASE_COUNT_OFS         = 8'h00;
   localparam logic [7:0]  TIMESTAMP_CONTROL_OFS       = 8'h04;
   localparam logic [7:0]  INTERRUPT_CODE_VECTOR_OFS   = 8'h08;
   localparam logic [7:0]  INTERRUPT_FLAGS_ENABLES_OFS = 8'h0c;
   localparam logic [7:0]  RECEIVE_PENDING_SUMMARY_OFS = 8'h10;
   localparam logic [7:0]  TRANSMIT_PENDING_SUMMARY_OFS = 8'h14;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int          FD_STAMP_POSITION_BIT  = 18;
   localparam int          END_OF_FRAME_STAMP_BIT = 17;
   localparam int          TIME_BASE_ENABLE_BIT   = 16;
   localparam int          PRESCALE_W             = 10;
   localparam int          RECEIVE_CODE_LSB       = 24;
   localparam int          TRANSMIT_CODE_LSB      = 16;
   localparam int          FILTER_HIT_LSB         = 8;
   localparam int          GENERAL_CODE_LSB       = 0;
   localparam int          ENABLE_HALF_LSB        = 16;
   localparam logic [31:0] TIME_BASE_RESET        = 32'h0000_0000;
   localparam logic [15:0] ENABLE_RESET           = 16'h0000;
   localparam logic [15:0] ENABLE_MASK            = 16'hff1f;
   localparam logic [15:0] STICKY_MASK            = 16'hf00c;

   // flag positions in the lower half of the interrupt register
   localparam int          INVALID_MESSAGE_BIT    = 15;
   localparam int          WAKEUP_BIT             = 14;
   localparam int          BUS_ERROR_BIT          = 13;
   localparam int          SYSTEM_ERROR_BIT       = 12;
   localparam int          RECEIVE_OVERFLOW_BIT   = 11;
   localparam int          TRANSMIT_ATTEMPT_BIT   = 10;
   localparam int          SERIAL_CHECK_BIT       = 9;
   localparam int          MEMORY_CORRECTION_BIT  = 8;
   localparam int          TRANSMIT_EVENT_BIT     = 4;
   localparam int          MODE_CHANGE_BIT        = 3;
   localparam int          TIMER_OVERFLOW_BIT     = 2;
   localparam int          RECEIVE_OBJECT_BIT     = 1;
   localparam int          TRANSMIT_OBJECT_BIT    = 0;

   // ----------------------------------------------------------------
   // vector codes
   // ----------------------------------------------------------------
   localparam logic [6:0]  CODE_NONE              = 7'h40;
   localparam logic [6:0]  CODE_BUS_ERROR         = 7'h41;
   localparam logic [6:0]  CODE_WAKEUP            = 7'h42;
   localparam logic [6:0]  CODE_RECEIVE_OVERFLOW  = 7'h43;
   localparam logic [6:0]  CODE_ADDRESS_ERROR     = 7'h44;
   localparam logic [6:0]  CODE_ASSEMBLY_FAULT    = 7'h45;
   localparam logic [6:0]  CODE_TIMER_OVERFLOW    = 7'h46;
   localparam logic [6:0]  CODE_MODE_CHANGE       = 7'h47;
   localparam logic [6:0]  CODE_INVALID_MESSAGE   = 7'h48;
   localparam logic [6:0]  CODE_TRANSMIT_EVENT    = 7'h49;
   localparam logic [6:0]  CODE_TRANSMIT_ATTEMPT  = 7'h4a;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0][2:0] rx_flags;
      logic [31:0][2:0] rx_enables;
      logic [31:0]      tx_pending;
      logic [31:0]      rx_overflow_pending;
      logic [31:0]      tx_attempt_pending;
      logic [31:0][4:0] filter_hit;
      logic             tef_pending;
   } tbi_fifo_status_type;

   typedef struct packed {
      logic sof_sample;
      logic fdf_sample;
      logic is_fd;
      logic bit_sample;
      logic frame_valid;
   } tbi_frame_events_type;

   typedef struct packed {
      logic       invalid_message;
      logic       wakeup;
      logic       bus_error;
      logic       assembly_fault;
      logic       address_error;
      logic       ram_collision;
      logic       serial_check_error;
      logic       memory_correction_error;
      logic [2:0] current_operating_mode;
      logic [2:0] requested_operating_mode;
   } tbi_module_events_type;

   typedef struct packed {
      logic [31:0]           time_base_counter;
      logic [PRESCALE_W-1:0] prescale_count;
      logic [PRESCALE_W-1:0] time_base_prescale;
      logic                  time_base_enable;
      logic                  end_of_frame_stamp;
      logic                  fd_stamp_position;
      logic [15:0]           enables;
      logic [15:0]           sticky;
      logic                  system_error_assembly;
      logic [2:0]            mode_seen;
      logic [31:0]           sof_snapshot;
      logic                  wait_next_bit;
      logic [31:0]           stamp;
      logic                  stamp_valid;
      logic [31:0]           rd_data;
   } tbi_state_type;

endpackage

//--- core/tbi_core.sv
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// How it works
// - enabled time base counts up once per prescaler period of module clocks
// - clearing the enable stops the counter and holds it at zero
// - a write to the counter register while enabled loads the counter and clears the prescaler count
// - prescaler value N gives one increment every N+1 clocks
// - fd frames with selector set stamp at sample point after the format bit
// - end-of-frame option stamps when the frame is taken as valid
// - otherwise classical frames stamp at start of frame, fd frames per selector
// - receive code shows 1000000 when idle, else pending receive fifo 1..31
// - transmit code shows 1000000 when idle, else pending transmit fifo 0..31
// - filter hit shows the filter number of the reported received message
// - every code field reports the pending source with the highest code
// - general code encodes module events with their fixed codes
// - general codes 0..31 name a fifo with transmit or receive pending
// - assembly buffer overrun or underrun reports system error code 1000101
// - illegal fifo address reports system error code 1000100
// - sticky event flags set only by hardware, cleared by software
// - a message ram collision sets the system error flag
// - mode change flag sets when current mode becomes the requested one
// - timer overflow flag sets when the counter overflows
// - summary flags are read only and show any pending object interrupt
// - upper-half enables gate the matching lower-half flags into the general code; flag bits 8 and 9 have no general code
// - receive pending bit is the or of that fifo's enabled flags
module tbi_core (
   input  wire logic                          i_clk_sys,
   input  wire logic                          i_sys_rst,
   input  wire logic [7:0]                    i_addr,
   input  wire logic [31:0]                   i_wr_data,
   input  wire logic                          i_wr_stb,
   input  wire logic                          i_rd_stb,
   input  wire tbi_pkg::tbi_fifo_status_type   i_fifo_status,
   input  wire tbi_pkg::tbi_frame_events_type  i_frame_events,
   input  wire tbi_pkg::tbi_module_events_type i_module_events,
   output logic [31:0]                        o_rd_data,
   output logic [31:0]                        o_time_base_counter,
   output logic [31:0]                        o_stamp,
   output logic                               o_stamp_valid
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // highest set bit; the top bit of the result says whether any was set
   function automatic logic [5:0] highest_set(input logic [31:0] v);
      logic [5:0] r;
      r = 6'h00;
      for (int i = 0; i < 32; i++) begin
         if (v[i]) begin
            r = {1'b1, 5'(i)};
         end
      end
      return r;
   endfunction

   // fifo code field: number when pending, else the idle code
   function automatic logic [6:0] fifo_code(input logic [5:0] h);
      return h[5] ? {2'b00, h[4:0]} : tbi_pkg::CODE_NONE;
   endfunction

   tbi_pkg::tbi_state_type s;
   tbi_pkg::tbi_state_type s_nxt;

   logic [31:0] rx_pending;
   logic [15:0] flags;
   logic [15:0] gated;
   logic [5:0]  rx_hi;
   logic [5:0]  tx_hi;
   logic [5:0]  gen_hi;
   logic [6:0]  receive_code;
   logic [6:0]  transmit_code;
   logic [4:0]  filter_hit_number;
   logic [6:0]  general_code;
   logic [31:0] vector_word;
   logic        wr_tbc;
   logic        wr_ctl;
   logic        wr_int;
   logic        tick;

   assign wr_tbc = i_wr_stb && (i_addr == tbi_pkg::TIME_BASE_COUNT_OFS);
   assign wr_ctl = i_wr_stb && (i_addr == tbi_pkg::TIMESTAMP_CONTROL_OFS);
   assign wr_int = i_wr_stb && (i_addr == tbi_pkg::INTERRUPT_FLAGS_ENABLES_OFS);
   assign tick   = s.time_base_enable && (s.prescale_count == s.time_base_prescale);

   // ----------------------------------------------------------------
   // status summaries and vector
   // ----------------------------------------------------------------
   // fifo zero never receives, so its summary bit stays zero
   always_comb begin
      rx_pending = 32'h0000_0000;
      for (int i = 1; i < 32; i++) begin
         rx_pending[i] = |(i_fifo_status.rx_flags[i] & i_fifo_status.rx_enables[i]);
      end
   end

   // lower half of the interrupt register, sticky and summary flags merged
   always_comb begin
      flags = s.sticky;
      flags[tbi_pkg::RECEIVE_OVERFLOW_BIT]  = |i_fifo_status.rx_overflow_pending;
      flags[tbi_pkg::TRANSMIT_ATTEMPT_BIT]  = |i_fifo_status.tx_attempt_pending;
      flags[tbi_pkg::SERIAL_CHECK_BIT]      = i_module_events.serial_check_error;
      flags[tbi_pkg::MEMORY_CORRECTION_BIT] = i_module_events.memory_correction_error;
      flags[tbi_pkg::TRANSMIT_EVENT_BIT]    = i_fifo_status.tef_pending;
      flags[tbi_pkg::RECEIVE_OBJECT_BIT]    = |rx_pending;
      flags[tbi_pkg::TRANSMIT_OBJECT_BIT]   = |i_fifo_status.tx_pending;
   end

   // enables gate the general code only; the register read shows raw flags
   assign gated = flags & s.enables;

   assign rx_hi  = highest_set(rx_pending);
   assign tx_hi  = highest_set(i_fifo_status.tx_pending);
   assign gen_hi = highest_set(
      ({32{gated[tbi_pkg::RECEIVE_OBJECT_BIT]}} & rx_pending) |
      ({32{gated[tbi_pkg::TRANSMIT_OBJECT_BIT]}} & i_fifo_status.tx_pending));

   assign receive_code      = fifo_code(rx_hi);
   assign transmit_code     = fifo_code(tx_hi);
   assign filter_hit_number = i_fifo_status.filter_hit[rx_hi[4:0]];

   // general code: the module events carry the higher codes, so they win
   always_comb begin
      if (gated[tbi_pkg::TRANSMIT_ATTEMPT_BIT]) begin
         general_code = tbi_pkg::CODE_TRANSMIT_ATTEMPT;
      end else if (gated[tbi_pkg::TRANSMIT_EVENT_BIT]) begin
         general_code = tbi_pkg::CODE_TRANSMIT_EVENT;
      end else if (gated[tbi_pkg::INVALID_MESSAGE_BIT]) begin
         general_code = tbi_pkg::CODE_INVALID_MESSAGE;
      end else if (gated[tbi_pkg::MODE_CHANGE_BIT]) begin
         general_code = tbi_pkg::CODE_MODE_CHANGE;
      end else if (gated[tbi_pkg::TIMER_OVERFLOW_BIT]) begin
         general_code = tbi_pkg::CODE_TIMER_OVERFLOW;
      end else if (gated[tbi_pkg::SYSTEM_ERROR_BIT] && s.system_error_assembly) begin
         general_code = tbi_pkg::CODE_ASSEMBLY_FAULT;
      end else if (gated[tbi_pkg::SYSTEM_ERROR_BIT]) begin
         general_code = tbi_pkg::CODE_ADDRESS_ERROR;
      end else if (gated[tbi_pkg::RECEIVE_OVERFLOW_BIT]) begin
         general_code = tbi_pkg::CODE_RECEIVE_OVERFLOW;
      end else if (gated[tbi_pkg::WAKEUP_BIT]) begin
         general_code = tbi_pkg::CODE_WAKEUP;
      end else if (gated[tbi_pkg::BUS_ERROR_BIT]) begin
         general_code = tbi_pkg::CODE_BUS_ERROR;
      end else begin
         general_code = fifo_code(gen_hi);
      end
   end

   always_comb begin
      vector_word = 32'h0000_0000;
      vector_word[tbi_pkg::RECEIVE_CODE_LSB +: 7]  = receive_code;
      vector_word[tbi_pkg::TRANSMIT_CODE_LSB +: 7] = transmit_code;
      vector_word[tbi_pkg::FILTER_HIT_LSB +: 5]    = filter_hit_number;
      vector_word[tbi_pkg::GENERAL_CODE_LSB +: 7]  = general_code;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [15:0] set_ev;
      logic [15:0] clr_ev;
      set_ev = 16'h0000;
      clr_ev = 16'h0000;
      s_nxt  = s;

      // time base; a counter write wins over the increment
      if (!s.time_base_enable) begin
         s_nxt.time_base_counter = tbi_pkg::TIME_BASE_RESET;
         s_nxt.prescale_count    = '0;
      end else if (wr_tbc) begin
         s_nxt.time_base_counter = i_wr_data;
         s_nxt.prescale_count    = '0;
      end else if (tick) begin
         s_nxt.prescale_count    = '0;
         s_nxt.time_base_counter = s.time_base_counter + 32'h0000_0001;
         set_ev[tbi_pkg::TIMER_OVERFLOW_BIT] = &s.time_base_counter;
      end else begin
         s_nxt.prescale_count = s.prescale_count + 10'h001;
      end

      if (wr_ctl) begin
         s_nxt.fd_stamp_position  = i_wr_data[tbi_pkg::FD_STAMP_POSITION_BIT];
         s_nxt.end_of_frame_stamp = i_wr_data[tbi_pkg::END_OF_FRAME_STAMP_BIT];
         s_nxt.time_base_enable   = i_wr_data[tbi_pkg::TIME_BASE_ENABLE_BIT];
         s_nxt.time_base_prescale = i_wr_data[tbi_pkg::PRESCALE_W-1:0];
      end

      // sticky event flags: hardware sets, software writes 0 to clear
      set_ev[tbi_pkg::INVALID_MESSAGE_BIT] = i_module_events.invalid_message;
      set_ev[tbi_pkg::WAKEUP_BIT]          = i_module_events.wakeup;
      set_ev[tbi_pkg::BUS_ERROR_BIT]       = i_module_events.bus_error;
      set_ev[tbi_pkg::SYSTEM_ERROR_BIT]    = i_module_events.assembly_fault |
                                             i_module_events.address_error |
                                             i_module_events.ram_collision;
      set_ev[tbi_pkg::MODE_CHANGE_BIT]     =
         (i_module_events.current_operating_mode != s.mode_seen) &&
         (i_module_events.current_operating_mode ==
          i_module_events.requested_operating_mode);
      s_nxt.mode_seen = i_module_events.current_operating_mode;
      if (wr_int) begin
         s_nxt.enables = i_wr_data[tbi_pkg::ENABLE_HALF_LSB +: 16] & tbi_pkg::ENABLE_MASK;
         clr_ev        = ~i_wr_data[15:0];
      end
      // set wins over a clear in the same cycle
      s_nxt.sticky = ((s.sticky & ~clr_ev) | set_ev) & tbi_pkg::STICKY_MASK;
      if (i_module_events.assembly_fault || i_module_events.ram_collision) begin
         s_nxt.system_error_assembly = 1'b1;
      end else if (i_module_events.address_error) begin
         s_nxt.system_error_assembly = 1'b0;
      end

      // time stamp; the start-of-frame count is held until the format is known
      s_nxt.stamp_valid = 1'b0;
      if (i_frame_events.sof_sample) begin
         s_nxt.sof_snapshot  = s.time_base_counter;
         s_nxt.wait_next_bit = 1'b0;
      end
      if (s.end_of_frame_stamp) begin
         if (i_frame_events.frame_valid) begin
            s_nxt.stamp       = s.time_base_counter;
            s_nxt.stamp_valid = 1'b1;
         end
      end else if (i_frame_events.fdf_sample) begin
         if (i_frame_events.is_fd && s.fd_stamp_position) begin
            s_nxt.wait_next_bit = 1'b1;
         end else begin
            s_nxt.stamp       = s.sof_snapshot;
            s_nxt.stamp_valid = 1'b1;
         end
      end else if (s.wait_next_bit && i_frame_events.bit_sample) begin
         s_nxt.stamp         = s.time_base_counter;
         s_nxt.stamp_valid   = 1'b1;
         s_nxt.wait_next_bit = 1'b0;
      end

      // read data stand for the one cycle after the strobe
      s_nxt.rd_data = 32'h0000_0000;
      if (i_rd_stb) begin
         unique case (i_addr)
            tbi_pkg::TIME_BASE_COUNT_OFS: begin
               s_nxt.rd_data = s.time_base_counter;
            end
            tbi_pkg::TIMESTAMP_CONTROL_OFS: begin
               s_nxt.rd_data[tbi_pkg::FD_STAMP_POSITION_BIT]  = s.fd_stamp_position;
               s_nxt.rd_data[tbi_pkg::END_OF_FRAME_STAMP_BIT] = s.end_of_frame_stamp;
               s_nxt.rd_data[tbi_pkg::TIME_BASE_ENABLE_BIT]   = s.time_base_enable;
               s_nxt.rd_data[tbi_pkg::PRESCALE_W-1:0]         = s.time_base_prescale;
            end
            tbi_pkg::INTERRUPT_CODE_VECTOR_OFS: begin
               s_nxt.rd_data = vector_word;
            end
            tbi_pkg::INTERRUPT_FLAGS_ENABLES_OFS: begin
               s_nxt.rd_data = {s.enables, flags};
            end
            tbi_pkg::RECEIVE_PENDING_SUMMARY_OFS: begin
               s_nxt.rd_data = rx_pending;
            end
            tbi_pkg::TRANSMIT_PENDING_SUMMARY_OFS: begin
               s_nxt.rd_data = i_fifo_status.tx_pending;
            end
            default: begin
               s_nxt.rd_data = 32'h0000_0000;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         s <= '0;
         s.enables <= tbi_pkg::ENABLE_RESET;
      end else begin
         s <= s_nxt;
      end
   end

   assign o_rd_data           = s.rd_data;
   assign o_time_base_counter = s.time_base_counter;
   assign o_stamp             = s.stamp;
   assign o_stamp_valid       = s.stamp_valid;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   tbc_halt_a: assert property (!s.time_base_enable |=> s.time_base_counter == 32'h0)
      else $error("time base not held at zero while disabled");

   tbc_step_a: assert property (tick && !wr_tbc |=>
      s.time_base_counter == $past(s.time_base_counter) + 32'h1)
      else $error("time base did not step at end of prescale period");

   tbc_hold_a: assert property (s.time_base_enable && !tick && !wr_tbc |=>
      $stable(s.time_base_counter))
      else $error("time base moved inside prescale period");

   pre_clear_a: assert property (wr_tbc && s.time_base_enable |=>
      s.prescale_count == '0 && s.time_base_counter == $past(i_wr_data))
      else $error("counter write did not clear prescale count");

   tbc_wrap_a: assert property (tick && !wr_tbc && &s.time_base_counter |=>
      s.time_base_counter == 32'h0 && s.sticky[tbi_pkg::TIMER_OVERFLOW_BIT])
      else $error("overflow did not wrap and flag");

   rx_code_a: assert property (rx_pending == 32'h0 |->
      receive_code == tbi_pkg::CODE_NONE)
      else $error("receive code not idle with nothing pending");

   rx_high_a: assert property (rx_pending[31] |->
      receive_code == 7'h1f && filter_hit_number == i_fifo_status.filter_hit[31])
      else $error("receive code not the highest fifo");

   tx_code_a: assert property (i_fifo_status.tx_pending == 32'h1 |->
      transmit_code == 7'h00)
      else $error("transmit queue not reported as code zero");

   txat_code_a: assert property (gated[tbi_pkg::TRANSMIT_ATTEMPT_BIT] |->
      general_code == tbi_pkg::CODE_TRANSMIT_ATTEMPT)
      else $error("transmit attempt not top general code");

   serr_set_a: assert property (i_module_events.ram_collision |=>
      s.sticky[tbi_pkg::SYSTEM_ERROR_BIT])
      else $error("collision did not set system error");

   mode_flag_a: assert property (
      i_module_events.current_operating_mode != s.mode_seen &&
      i_module_events.current_operating_mode ==
      i_module_events.requested_operating_mode |=> s.sticky[tbi_pkg::MODE_CHANGE_BIT])
      else $error("mode change flag not set");

   eof_stamp_a: assert property (s.end_of_frame_stamp && i_frame_events.frame_valid |=>
      o_stamp_valid && o_stamp == $past(s.time_base_counter))
      else $error("end of frame stamp missing");

endmodule

//--- verification/tbi_engine_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// protocol engine stand-in: one frame per start request
// ----------------------------------------------------------------
module tbi_engine_model (
   input  wire logic                     i_clk_sys,
   input  wire logic                     i_start,
   input  wire logic                     i_fd,
   input  wire logic [3:0]               i_gap,
   output tbi_pkg::tbi_frame_events_type o_ev
);
   // is_fd shows the wrong level away from the format bit sample
   task automatic beat(input logic [3:0] m);
      o_ev <= {m[3:2], m[2] ? i_fd : ~i_fd, m[1:0]};
      @(posedge i_clk_sys);
      o_ev <= {2'b00, ~i_fd, 2'b00};
      repeat (i_gap) @(posedge i_clk_sys);
   endtask
   // start of frame, format bit, next bit, frame valid; gap sets the pace
   always @(posedge i_clk_sys) begin
      if (i_start) begin
         beat(4'h8);
         beat(4'h4);
         beat(4'h2);
         beat(4'h1);
      end
   end
   initial o_ev = '0;
endmodule

//--- verification/tbi_core_tb.sv
`timescale 1ns/1ps
module tbi_core_tb;
   logic                           clk = 1'b0;
   logic                           rst = 1'b1;
   logic                           wstb = 1'b0, rstb = 1'b0, go = 1'b0, fd = 1'b0, sv;
   logic [7:0]                     addr = 8'h00;
   logic [3:0]                     gap = 4'h0;
   logic [31:0]                    wdat = 32'h0, rdv, v, r, rdd, cnt, stamp, sof_t, bit_t, val_t;
   tbi_pkg::tbi_fifo_status_type   fs = '0, s;
   tbi_pkg::tbi_frame_events_type  ev;
   tbi_pkg::tbi_module_events_type me = 14'h0003;
   int                             failures = 0, checked = 0, ns = 0, n;
   int                             seed = 32'h37c5955f;
   logic [13:0]                    tab [7] = '{14'h2003, 14'h1003, 14'h0803, 14'h0203,
                                               14'h0403, 14'h0103, 14'h001b};
   logic [6:0]                     gc [7] = '{7'h48, 7'h42, 7'h41, 7'h44, 7'h45, 7'h45, 7'h47};
   int                             fb [7] = '{15, 14, 13, 12, 12, 12, 3};

   tbi_core u_tbi_core (.i_clk_sys(clk), .i_sys_rst(rst), .i_addr(addr), .i_wr_data(wdat),
      .i_wr_stb(wstb), .i_rd_stb(rstb), .i_fifo_status(fs), .i_frame_events(ev),
      .i_module_events(me), .o_rd_data(rdd), .o_time_base_counter(cnt), .o_stamp(stamp),
      .o_stamp_valid(sv));
   tbi_engine_model u_tbi_engine_model (.i_clk_sys(clk), .i_start(go), .i_fd(fd),
      .i_gap(gap), .o_ev(ev));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   always #2 clk = ~clk;
   // counter value at start of frame, next bit and frame valid, and count of stamp pulses
   always @(posedge clk) begin
      if (ev.sof_sample) sof_t <= cnt;
      if (ev.bit_sample) bit_t <= cnt;
      if (ev.frame_valid) val_t <= cnt;
      if (sv) ns <= ns + 1;
   end
   function automatic logic [6:0] top(input logic [31:0] x);
      top = 7'h40;
      for (int i = 0; i < 32; i++) if (x[i]) top = 7'(i);
   endfunction
   // fifo 0 never receives, so its bit stays low
   function automatic logic [31:0] rxsum(input tbi_pkg::tbi_fifo_status_type q);
      rxsum = '0;
      for (int i = 1; i < 32; i++) rxsum[i] = |(q.rx_flags[i] & q.rx_enables[i]);
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
      checked++;
      if (seen !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
      end
   endtask
   // a trailing edge keeps strobes from being driven twice in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdat <= d;
      wstb <= 1'b1;
      @(posedge clk);
      wstb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      addr <= a;
      rstb <= 1'b1;
      @(posedge clk);
      rstb <= 1'b0;
      @(posedge clk);
      rdv = rdd;
      chk($sformatf("reg %h", a), rdv & m, e & m);
   endtask
   task automatic complete_run();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      failures++;
      complete_run();
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rc(8'h08, 32'h4040_0040, '1);
      rc(8'h04, 32'h0, '1);
      rc(8'h0c, 32'h0, '1);
      rc(8'h18, 32'h0, '1);
      // prescale edges: zero, largest and random small values
      for (int j = 0; j < 4; j++) begin
         n = (j == 0) ? 0 : (j == 1) ? 1023 : ($random(seed) & 15);
         v = $random(seed);
         wr(8'h04, 32'h0001_0000 | n);
         wr(8'h00, v);
         chk("count", cnt, v);
         for (int k = 1; k < 3; k++) begin
            repeat (n) @(posedge clk);
            chk("count", cnt, v + k - 1);
            @(posedge clk);
            chk("count", cnt, v + k);
         end
      end
      wr(8'h04, 32'h0001_0000);
      wr(8'h0c, 32'hff1f_0000);
      wr(8'h00, 32'hffff_fffe);
      repeat (2) @(posedge clk);
      chk("wrap", cnt, 32'h0);
      rc(8'h0c, 32'h4, 32'h4);
      rc(8'h08, 32'h46, 32'h7f);
      wr(8'h0c, 32'hff1b_0003);
      rc(8'h08, 32'h40, 32'h7f);
      rc(8'h0c, 32'h0, 32'h4);
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h1234);
      repeat (2) @(posedge clk);
      chk("stopped", cnt, 32'h0);
      // sparse random pending sets, first one empty
      for (int k = 0; k < 20; k++) begin
         s = '0;
         for (int f = 0; f < 32; f++) begin
            s.rx_flags[f] = (k > 0 && ($random(seed) & 7) == 0) ? 3'h7 : 3'h0;
            s.rx_enables[f] = 3'($random(seed));
            s.filter_hit[f] = 5'($random(seed));
         end
         s.tx_pending = $random(seed) & $random(seed) & $random(seed);
         if (k < 2) s.tx_pending = 32'(k); // empty first, then the transmit queue as the only transmit fifo pending
         fs <= s;
         r = rxsum(s);
         rc(8'h10, r, '1);
         rc(8'h0c, {30'h0, |r, |s.tx_pending}, 32'h3);
         rc(8'h08, {1'b0, top(r), 1'b0, top(s.tx_pending), 9'h0, top(r | s.tx_pending)},
            32'h7f7f_007f);
         if (r != 0) rc(8'h08, {19'h0, s.filter_hit[top(r)], 8'h0}, 32'h1f00);
      end
      fs <= '0;
      for (int e = 0; e < 7; e++) begin
         me <= tab[e];
         @(posedge clk);
         me <= 14'h0003;
         rc(8'h0c, 32'h1 << fb[e], 32'h1 << fb[e]);
         rc(8'h08, gc[e], 32'h7f);
         wr(8'h0c, 32'hff1b_0000);
         rc(8'h0c, 32'h0, 32'hf00c);
      end
      // summary levels pile up: overflow, then event queue, then attempt on top
      for (int e = 0; e < 3; e++) begin
         s = '0;
         s.rx_overflow_pending[5] = 1'b1;
         s.tef_pending = e > 0;
         s.tx_attempt_pending[31] = e > 1;
         fs <= s;
         rc(8'h0c, {21'h0, e > 1, 5'h0, e > 0, 4'h0} | 32'h800, 32'hc10);
         rc(8'h08, (e == 0) ? 32'h43 : 32'h48 + e, 32'h7f);
      end
      // attempt enable off: the event queue code must show through
      wr(8'h0c, 32'hfb1b_0000);
      rc(8'h08, 32'h49, 32'h7f);
      fs <= '0;
      // every mix of end-of-frame option, fd position and frame format
      for (int i = 0; i < 8; i++) begin
         wr(8'h04, 32'h0001_0000 | (32'(i[2:1]) << 17));
         fd <= i[0];
         gap <= 4'($random(seed));
         go <= 1'b1;
         ns = 0;
         @(posedge clk);
         go <= 1'b0;
         repeat (4 * gap + 8) @(posedge clk);
         chk("stamp", stamp, i[1] ? val_t : (i[2] & i[0]) ? bit_t : sof_t);
         chk("stamps", ns, 32'h1);
      end
      complete_run();
   end
endmodule
